// ===== design/frc_pkg.sv
// constants and types shared by the retransmit-capable fifo
package frc_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int FRC_WIDTH = 36;
    localparam int FRC_ADDR_W = 10;
    localparam int FRC_DEPTH = 1024;
    localparam logic [FRC_ADDR_W:0] FRC_DEPTH_CNT = 11'h400;
    // ------------------------------------------------------------
    // flag thresholds and timing
    // ------------------------------------------------------------
    localparam logic [FRC_ADDR_W:0] FRC_HALF_CNT = 11'h200;
    localparam logic [FRC_ADDR_W:0] FRC_AE_OFFSET = 11'h07f;
    localparam logic [FRC_ADDR_W:0] FRC_AF_OFFSET = 11'h07f;
    localparam logic [FRC_ADDR_W:0] FRC_MIN_REPLAY_WORDS = 11'h002;
    localparam logic [1:0] FRC_SETUP_CYCLES = 2'h2;
    localparam logic [FRC_ADDR_W-1:0] FRC_FIRST_LOC = 10'h000;
    localparam logic [FRC_ADDR_W:0] FRC_ONE = 11'h001;
    localparam logic [1:0] FRC_SYNC_RST = 2'h0;
    typedef enum logic [1:0] {FRC_IDLE, FRC_SETUP, FRC_DONE} frc_state_t;
endpackage : frc_pkg

// ===== design/frc_fifo.sv
// retransmit-capable 36-bit fifo, single clock, with standard and fall-through flags
//
// Behaviour
// - standard mode: setup ends as empty flag returns high; reads wait.
// - fall-through mode: setup ends as output-ready returns low.
// - fall-through: input-ready stays low through setup under the write limit.
// - timing select high at master clear picks normal replay with setup wait.
// - timing select low at master clear picks zero-latency replay.
// - zero latency from empty: empty flag and output updated on request cycle.
// - replay restarts with first word after master clear, then write order.
`timescale 1ns/1ps
module frc_fifo
    import frc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic master_clear_n,
    input wire logic fall_through_mode,
    input wire logic replay_timing_select,
    input wire logic replay_request,
    input wire logic write_en,
    input wire logic [FRC_WIDTH-1:0] write_data,
    input wire logic read_en,
    output logic [FRC_WIDTH-1:0] read_data,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic half_level_flag_n,
    output logic almost_full_flag_n,
    output logic replay_busy
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] clr_sync_reg;
    logic [1:0] mode_sync_reg;
    logic [1:0] rtsel_sync_reg;
    logic clear_n;
    logic ft_in;
    logic rtsel_in;

    // master clear and straps come from pins, two flops each
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clr_sync_reg <= FRC_SYNC_RST;
            mode_sync_reg <= FRC_SYNC_RST;
            rtsel_sync_reg <= FRC_SYNC_RST;
        end else if (clk_en) begin
            clr_sync_reg <= {clr_sync_reg[0], master_clear_n};
            mode_sync_reg <= {mode_sync_reg[0], fall_through_mode};
            rtsel_sync_reg <= {rtsel_sync_reg[0], replay_timing_select};
        end
    end
    assign clear_n = clr_sync_reg[1];
    assign ft_in = mode_sync_reg[1];
    assign rtsel_in = rtsel_sync_reg[1];

    // ------------------------------------------------------------
    // mode latches, caught while master clear is held
    // ------------------------------------------------------------
    logic ft_reg;
    logic normal_rt_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ft_reg <= 1'b0;
            normal_rt_reg <= 1'b1;
        end else if (clk_en && !clear_n) begin
            ft_reg <= ft_in;
            normal_rt_reg <= rtsel_in;
        end
    end

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [FRC_WIDTH-1:0] mem_reg [FRC_DEPTH];
    logic [FRC_ADDR_W-1:0] wptr_reg;
    logic [FRC_ADDR_W-1:0] rptr_reg;
    logic [FRC_ADDR_W:0] count_reg;
    logic [FRC_ADDR_W:0] count_next;
    frc_state_t state_reg;
    logic [1:0] setup_cnt_reg;
    logic do_write;
    logic do_read;
    logic take_replay;
    logic hold_reads;
    logic ft_present;

    // replay taken on a read edge; the minimum-words check guards misuse
    assign take_replay = replay_request && (count_reg >= FRC_MIN_REPLAY_WORDS ||
        wptr_reg >= FRC_MIN_REPLAY_WORDS[FRC_ADDR_W-1:0]);
    assign hold_reads = (state_reg == FRC_SETUP);
    // fall-through hands word one to the output as setup ends, so it counts as read
    assign ft_present = ft_reg && hold_reads && (setup_cnt_reg == 2'h1);
    assign do_write = write_en && (count_next_full(count_reg) == 1'b0);
    assign do_read = read_en && !hold_reads && !take_replay && (count_reg != '0);

    // the count is an argument so the continuous assignment follows its changes
    function automatic logic count_next_full(input logic [FRC_ADDR_W:0] cnt);
        count_next_full = (cnt == FRC_DEPTH_CNT);
    endfunction : count_next_full

    // write side keeps advancing; replay never moves it
    always_ff @(posedge core_clk) begin
        if (clk_en && do_write) begin
            mem_reg[wptr_reg] <= write_data;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wptr_reg <= FRC_FIRST_LOC;
        end else if (clk_en) begin
            if (!clear_n) begin
                wptr_reg <= FRC_FIRST_LOC;
            end else if (do_write) begin
                wptr_reg <= wptr_reg + FRC_ONE[FRC_ADDR_W-1:0];
            end
        end
    end

    // rewind the read pointer to the first stored word, or to the second under zero latency
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rptr_reg <= FRC_FIRST_LOC;
        end else if (clk_en) begin
            if (!clear_n) begin
                rptr_reg <= FRC_FIRST_LOC;
            end else if (take_replay) begin
                rptr_reg <= FRC_FIRST_LOC + (normal_rt_reg ? '0 : FRC_ONE[FRC_ADDR_W-1:0]);
            end else if (do_read || ft_present) begin
                rptr_reg <= rptr_reg + FRC_ONE[FRC_ADDR_W-1:0];
            end
        end
    end

    // occupancy recomputed from the write pointer on replay
    always_comb begin
        count_next = count_reg;
        if (take_replay) begin
            // zero latency presents word one now, so it is already consumed
            count_next = {1'b0, wptr_reg} + (do_write ? FRC_ONE : '0) -
                (normal_rt_reg ? '0 : FRC_ONE);
        end else begin
            count_next = count_reg + (do_write ? FRC_ONE : '0) -
                ((do_read || ft_present) ? FRC_ONE : '0);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (clk_en) begin
            count_reg <= clear_n ? count_next : '0;
        end
    end

    // ------------------------------------------------------------
    // replay setup sequence
    // ------------------------------------------------------------
    // normal timing holds reads for a short setup; zero latency skips it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= FRC_IDLE;
            setup_cnt_reg <= '0;
        end else if (clk_en) begin
            if (!clear_n) begin
                state_reg <= FRC_IDLE;
                setup_cnt_reg <= '0;
            end else begin
                unique case (state_reg)
                    FRC_IDLE: begin
                        if (take_replay && normal_rt_reg) begin
                            state_reg <= FRC_SETUP;
                            setup_cnt_reg <= FRC_SETUP_CYCLES;
                        end
                    end
                    FRC_SETUP: begin
                        setup_cnt_reg <= setup_cnt_reg - 2'h1;
                        if (setup_cnt_reg == 2'h1) begin
                            state_reg <= FRC_DONE;
                        end
                    end
                    FRC_DONE: begin
                        state_reg <= FRC_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // output data and flags
    // ------------------------------------------------------------
    // zero latency drives word one on the request edge, even from empty
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            read_data <= '0;
        end else if (clk_en) begin
            if (take_replay && !normal_rt_reg) begin
                read_data <= mem_reg[FRC_FIRST_LOC];
            end else if (do_read || ft_present) begin
                read_data <= mem_reg[rptr_reg];
            end
        end
    end

    // flags are active low; setup forces not-ready and lifts at completion
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            empty_flag_n <= 1'b0;
            full_flag_n <= 1'b1;
            almost_empty_flag_n <= 1'b0;
            half_level_flag_n <= 1'b1;
            almost_full_flag_n <= 1'b1;
            replay_busy <= 1'b0;
        end else if (clk_en) begin
            // fall-through polarity: output-ready low means data is ready
            if (take_replay && normal_rt_reg) begin
                empty_flag_n <= ft_reg;
            end else if (hold_reads && setup_cnt_reg != 2'h1) begin
                empty_flag_n <= ft_reg;
            end else begin
                empty_flag_n <= ft_reg ? (count_next == '0) : (count_next != '0);
            end
            // in fall-through this is input-ready, low means accepting; the
            // writer limit keeps it asserted across setup
            full_flag_n <= ft_reg ? (count_next == FRC_DEPTH_CNT) :
                (count_next != FRC_DEPTH_CNT);
            almost_empty_flag_n <= (count_next > FRC_AE_OFFSET);
            half_level_flag_n <= (count_next <= FRC_HALF_CNT);
            almost_full_flag_n <= (count_next < FRC_DEPTH_CNT - FRC_AF_OFFSET);
            replay_busy <= (take_replay && normal_rt_reg) ||
                (hold_reads && setup_cnt_reg != 2'h1);
        end
    end
endmodule : frc_fifo

// ===== testbench/frc_writer_model.sv
// writer-side partner model: streams numbered words into the fifo
`timescale 1ns/1ps
module frc_writer_model
    import frc_pkg::*;
(
    input wire logic core_clk,
    input wire logic start,
    input wire logic [7:0] count,
    input wire logic [FRC_WIDTH-1:0] base,
    input wire logic room,
    output logic write_en,
    output logic [FRC_WIDTH-1:0] write_data,
    output logic idle
);
    logic [7:0] left = 8'h00;
    logic [FRC_WIDTH-1:0] nxt = 36'h0;
    assign idle = (left == 8'h00) && !write_en;
    // a word only counts as stored once the fifo had room on that edge
    always @(posedge core_clk) begin
        if (start) begin
            left <= count;
            nxt <= base;
        end else if (write_en && room) begin
            left <= left - 8'h01;
            nxt <= nxt + 36'h1;
        end
    end
    // released data lines carry the inverse so stale words cannot match
    always @(negedge core_clk) begin
        write_en <= (left != 8'h00);
        write_data <= (left != 8'h00) ? nxt : ~nxt;
    end
endmodule : frc_writer_model

// ===== testbench/frc_fifo_assertions.sv
// concurrent checks on the retransmit fifo ports
`timescale 1ns/1ps
module frc_fifo_assertions
    import frc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic master_clear_n,
    input wire logic fall_through_mode,
    input wire logic replay_timing_select,
    input wire logic replay_request,
    input wire logic write_en,
    input wire logic [FRC_WIDTH-1:0] write_data,
    input wire logic full_flag_n,
    input wire logic empty_flag_n,
    input wire logic [FRC_WIDTH-1:0] read_data,
    input wire logic replay_busy
);
    logic seen_reg;
    logic [FRC_WIDTH-1:0] first_reg;
    // first word taken after a clear; zero-latency replay must show it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_reg <= 1'b0;
            first_reg <= 36'h0;
        end else if (!master_clear_n) begin
            seen_reg <= 1'b0;
        end else if (write_en && !seen_reg && (fall_through_mode ^ full_flag_n)) begin
            seen_reg <= 1'b1;
            first_reg <= write_data;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_SETUP_BOUNDED: assert property ($rose(replay_busy) |-> ##[1:3] !replay_busy)
        else $error("replay setup too long");
    AST_STD_SETUP_EMPTY: assert property (replay_busy && !fall_through_mode |-> !empty_flag_n)
        else $error("empty flag high during setup");
    AST_FT_SETUP_HOLD: assert property (replay_busy && fall_through_mode |-> empty_flag_n)
        else $error("output ready during setup");
    AST_FT_SETUP_ACCEPT: assert property (replay_busy && fall_through_mode |-> !full_flag_n)
        else $error("input not accepting during setup");
    AST_BUSY_CAUSE: assert property ($rose(replay_busy) |-> $past(replay_request))
        else $error("setup started without a request");
    AST_ZERO_NO_SETUP: assert property (replay_request && !replay_timing_select |=> !replay_busy)
        else $error("zero latency replay entered setup");
    AST_ZERO_EMPTY_UPD: assert property (replay_request && !replay_timing_select
        && !fall_through_mode && !empty_flag_n && seen_reg |=> empty_flag_n)
        else $error("empty flag not updated on replay");
    AST_ZERO_FIRST: assert property (replay_request && !replay_timing_select
        && !fall_through_mode && seen_reg |=> read_data == first_reg)
        else $error("replay did not present first word");
    cover property ($rose(replay_busy) && !fall_through_mode);
    cover property ($rose(replay_busy) && fall_through_mode);
    cover property (replay_request && !replay_timing_select);
endmodule : frc_fifo_assertions
bind frc_fifo frc_fifo_assertions u_frc_fifo_assertions (.core_clk, .rst, .master_clear_n,
    .fall_through_mode, .replay_timing_select, .replay_request, .write_en, .write_data,
    .full_flag_n, .empty_flag_n, .read_data, .replay_busy);

// ===== testbench/tb_top.sv
// self-checking bench for the retransmit-capable fifo
`timescale 1ns/1ps
module tb_top;
    import frc_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, master_clear_n = 1'b1, start = 1'b0;
    logic fall_through_mode = 1'b0, replay_timing_select = 1'b1, replay_request = 1'b0;
    logic read_en = 1'b0, write_en, empty_flag_n, full_flag_n, replay_busy, room, idle;
    logic almost_empty_flag_n, half_level_flag_n, almost_full_flag_n;
    logic [7:0] count = 8'h00;
    logic [FRC_WIDTH-1:0] base = 36'h0, read_data, write_data;
    int err_count = 0, samples_checked = 0;
    assign room = fall_through_mode ^ full_flag_n;
    always #25 core_clk = ~core_clk;
    frc_fifo u_frc_fifo (.core_clk, .rst, .clk_en, .master_clear_n, .fall_through_mode,
        .replay_timing_select, .replay_request, .write_en, .write_data, .read_en, .read_data,
        .empty_flag_n, .full_flag_n, .almost_empty_flag_n, .half_level_flag_n,
        .almost_full_flag_n, .replay_busy);
    frc_writer_model u_frc_writer_model (.core_clk, .start, .count, .base, .room, .write_en,
        .write_data, .idle);
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // bounded wait; a hang is counted and ends the run
    task automatic wait_on(ref logic sig, input logic want);
        int i;
        for (i = 0; i < 40 && sig !== want; i++) @(negedge core_clk);
        if (i == 40) begin
            err_count++;
            final_report();
        end
    endtask : wait_on
    // straps are only latched while the clear is low
    task automatic clear(input logic ftm, input logic tsel);
        master_clear_n = 1'b0;
        fall_through_mode = ftm;
        replay_timing_select = tsel;
        repeat (4) @(negedge core_clk);
        master_clear_n = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask : clear
    task automatic fill(input logic [7:0] n, input logic [35:0] b);
        start = 1'b1;
        count = n;
        base = b;
        @(negedge core_clk);
        start = 1'b0;
        wait_on(idle, 1'b1);
    endtask : fill
    task automatic rd(input int n, input logic [35:0] b);
        read_en = 1'b1;
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            chk(read_data, b + 36'(i));
        end
        read_en = 1'b0;
    endtask : rd
    task automatic req();
        replay_request = 1'b1;
        @(negedge core_clk);
        replay_request = 1'b0;
    endtask : req
    // normal timing, standard flags: refusal, setup wait, replay order
    task automatic t_std_normal();
        clear(1'b0, 1'b1);
        fill(8'h01, 36'h1_0000_0000);
        req();
        chk(36'(replay_busy), 36'h0);
        fill(8'h03, 36'h1_0000_0001);
        rd(2, 36'h1_0000_0000);
        req();
        chk(36'(replay_busy), 36'h1);
        chk(36'(empty_flag_n), 36'h0);
        chk(36'(almost_empty_flag_n), 36'h0);
        chk(36'(half_level_flag_n), 36'h1);
        chk(36'(almost_full_flag_n), 36'h1);
        wait_on(empty_flag_n, 1'b1);
        rd(4, 36'h1_0000_0000);
        $display("standard normal replay finished");
    endtask : t_std_normal
    // zero latency from an empty fifo
    task automatic t_std_zero();
        clear(1'b0, 1'b0);
        fill(8'h03, 36'h2_0000_0000);
        rd(3, 36'h2_0000_0000);
        chk(36'(empty_flag_n), 36'h0);
        req();
        chk(36'(empty_flag_n), 36'h1);
        chk(read_data, 36'h2_0000_0000);
        // a held clock enable must freeze the replayed word and the pointers
        clk_en = 1'b0;
        read_en = 1'b1;
        @(negedge core_clk);
        chk(read_data, 36'h2_0000_0000);
        chk(36'(empty_flag_n), 36'h1);
        clk_en = 1'b1;
        rd(2, 36'h2_0000_0001);
        $display("zero latency replay finished");
    endtask : t_std_zero
    // fall-through flags under normal timing
    task automatic t_ft_normal();
        clear(1'b1, 1'b1);
        fill(8'h03, 36'h3_0000_0000);
        wait_on(empty_flag_n, 1'b0);
        rd(2, 36'h3_0000_0000);
        req();
        chk(36'(full_flag_n), 36'h0);
        chk(36'(empty_flag_n), 36'h1);
        wait_on(empty_flag_n, 1'b0);
        chk(read_data, 36'h3_0000_0000);
        rd(2, 36'h3_0000_0001);
        $display("fall-through replay finished");
    endtask : t_ft_normal
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        t_std_normal();
        t_std_zero();
        t_ft_normal();
        final_report();
    end
endmodule : tb_top
